// file: bench/rie_isa_target.sv
// behavioural expansion card standing on the far side of the port
`timescale 1ns/1ps
module rie_isa_target (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // card bus from the port
    input wire logic [rie_pkg::BANK_W-1:0] card_upper_addr,
    input wire logic [rie_pkg::ISA_ADDR_W-1:0] isa_addr,
    input wire logic [rie_pkg::ISA_DATA_W-1:0] isa_data_out,
    input wire logic [1:0] isa_data_oe,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic io_read_n,
    input wire logic io_write_n,
    input wire logic ext_buffer_gate_n,
    input wire logic ext_buffer_rd,
    // card answers
    output logic [rie_pkg::ISA_DATA_W-1:0] isa_data_in,
    output logic mem_wide_sel_n,
    output logic io_wide_sel_n,
    output logic chan_ready,
    // bench knobs and records
    input wire logic [1:0] stretch,
    output logic [3:0] last_len,
    output logic [rie_pkg::BANK_W-1:0] last_upper,
    output logic [rie_pkg::ISA_ADDR_W-1:0] last_addr,
    output logic last_io,
    output logic [1:0] last_oe,
    output logic [rie_pkg::ISA_DATA_W-1:0] last_wdata,
    output logic bus_bad
);
    import rie_pkg::*;
    logic rd_act;
    logic strb;
    logic wide;
    logic [15:0] rd_val;
    logic [15:0] held_reg;
    logic [3:0] cnt_reg;

    // ************************************
    // decode and answers
    // ************************************
    assign rd_act = !mem_read_n || !io_read_n;
    assign strb = rd_act || !mem_write_n || !io_write_n;
    // wide card sits at logical A00000h..BFFFFFh
    assign wide = (card_upper_addr == 2'h2) && isa_addr[21];
    // driven both ways: low for the wide card, high otherwise in place of a pull-up
    assign mem_wide_sel_n = !wide;
    assign io_wide_sel_n = !wide;
    assign rd_val = isa_addr[15:0] ^ 16'hC33C;
    // released bus must not look like it kept the last value
    assign isa_data_in = rd_act ? rd_val : ~held_reg;
    assign chan_ready = !(strb && cnt_reg >= 4'h2 && cnt_reg < 4'h2 + {2'h0, stretch});

    // ************************************
    // cycle records
    // ************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            last_len <= 4'h0;
            bus_bad <= 1'b0;
        end else begin
            if (rd_act) held_reg <= rd_val;
            if (strb) begin
                cnt_reg <= cnt_reg + 4'h1;
                last_upper <= card_upper_addr;
                last_addr <= isa_addr;
                last_io <= !io_read_n || !io_write_n;
                last_oe <= isa_data_oe;
                last_wdata <= isa_data_out;
                if ((cnt_reg != 4'h0 && isa_addr != last_addr) || ext_buffer_gate_n
                    || ext_buffer_rd != rd_act) bus_bad <= 1'b1;
            end else begin
                if (cnt_reg != 4'h0) last_len <= cnt_reg;
                cnt_reg <= 4'h0;
            end
        end
    end
endmodule : rie_isa_target

// file: bench/testbench.sv
// self-checking bench for the reduced isa expansion port
`timescale 1ns/1ps
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
module testbench;
    import rie_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r, a;
    logic [1:0] card_upper_addr, isa_data_oe, fld, stretch, last_upper, last_oe;
    logic [21:0] isa_addr, off, last_addr;
    logic [15:0] isa_data_in, isa_data_out, last_wdata, rv;
    logic mem_read_n, mem_write_n, io_read_n, io_write_n, mem_wide_sel_n, io_wide_sel_n;
    logic chan_ready, ext_buffer_gate_n, ext_buffer_rd, last_io, bus_bad, io, wr, wide;
    logic [3:0] irq_pin, irq_req, last_len;
    logic [1:0] dma_request_n, dma_acknowledge_n, cpu_dma_req, cpu_dma_ack;
    logic [7:0] sel;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    integer seed = 32'h3e74;

    rie_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .card_upper_addr, .isa_addr, .isa_data_in, .isa_data_out,
        .isa_data_oe, .mem_read_n, .mem_write_n, .io_read_n, .io_write_n, .mem_wide_sel_n,
        .io_wide_sel_n, .chan_ready, .ext_buffer_gate_n, .ext_buffer_rd, .irq_pin, .irq_req,
        .dma_request_n, .dma_acknowledge_n, .cpu_dma_req, .cpu_dma_ack);
    rie_isa_target card (.pclk, .presetn, .card_upper_addr, .isa_addr, .isa_data_out,
        .isa_data_oe, .mem_read_n, .mem_write_n, .io_read_n, .io_write_n,
        .ext_buffer_gate_n, .ext_buffer_rd, .isa_data_in, .mem_wide_sel_n, .io_wide_sel_n,
        .chan_ready, .stretch, .last_len, .last_upper, .last_addr, .last_io, .last_oe,
        .last_wdata, .bus_bad);

    always #50 pclk = ~pclk;

    // ************************************
    // tasks
    // ************************************
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // card cycles have no upper bound, so only the bench timeout ends the wait
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                       input logic [32:0] ex);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        if (!w) exp_q.push_back(ex);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic irq_step(input logic [3:0] pin, input logic [3:0] ex);
        @(posedge pclk);
        irq_pin <= pin;
        repeat (4) @(posedge pclk);
        #1;
        `CHK(irq_req, ex)
    endtask : irq_step

    // ************************************
    // read result watcher and timeout
    // ************************************
    always @(posedge pclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1) begin
            e = exp_q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        irq_pin = 4'h0;
        dma_request_n = 2'h3;
        cpu_dma_ack = 2'h0;
        stretch = 2'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_SEL_ADDR, 32'h0, {1'b0, 32'h0});
        apb(1'b0, IRQ_MASK_ADDR, 32'h0, {1'b0, 32'hE});
        apb(1'b0, 32'h1100_07F0, 32'h0, {1'b1, 32'h0});
        // every mix of space, direction and width, twice with fresh randoms
        for (int i = 0; i < 16; i++) begin
            {wide, wr, io} = i[2:0];
            r = $random(seed);
            a = $random(seed);
            sel = r[7:0];
            fld = wide ? 2'h2 : {1'b0, r[8]};
            if (io) sel[5:4] = fld;
            else sel[1:0] = fld;
            off = {wide | a[21], a[20:0]};
            rv = off[15:0] ^ 16'hC33C;
            stretch = r[10:9];
            apb(1'b1, ADDR_SEL_ADDR, {24'h0, sel}, 33'h0);
            apb(wr, (io ? IO_WIN_BASE : MEM_WIN_BASE) | {10'h0, off}, r,
                {1'b0, wide ? {16'h0, rv} : {24'h0, rv[7:0]}});
            #1;
            `CHK(last_upper, fld)
            `CHK(last_io, io)
            `CHK(last_addr, off)
            `CHK(last_len, 4'h3 + {2'h0, stretch})
            apb(1'b0, PORT_STAT_ADDR, 32'h0, {1'b0, 31'h0, wide});
            if (wr) begin
                `CHK(last_oe, {wide, 1'b1})
                `CHK(last_wdata & {{8{wide}}, 8'hFF}, r[15:0] & {{8{wide}}, 8'hFF})
            end
        end
        irq_step(4'hE, 4'h0);
        irq_step(4'hF, 4'h1);
        irq_step(4'h0, 4'h1);
        apb(1'b1, IRQ_PEND_ADDR, 32'h1, 33'h0);
        irq_step(4'h0, 4'h0);
        irq_step(4'h1, 4'h1);
        apb(1'b0, IRQ_PEND_ADDR, 32'h0, {1'b0, 32'h1});
        apb(1'b1, IRQ_PEND_ADDR, 32'h1, 33'h0);
        irq_step(4'h1, 4'h0);
        apb(1'b1, IRQ_MASK_ADDR, 32'h0, 33'h0);
        irq_step(4'hF, 4'hE);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            @(posedge pclk);
            dma_request_n <= r[1:0];
            cpu_dma_ack <= r[3:2];
            repeat (2) @(posedge pclk);
            #1;
            `CHK(cpu_dma_req, ~r[1:0])
            `CHK(dma_acknowledge_n, ~r[3:2])
        end
        `CHK(bus_bad, 1'b0)
        report_and_stop();
    end
endmodule : testbench

// file: src/rie_irq_sense.sv
// interrupt input sensing and masking for the expansion port
`timescale 1ns/1ps
module rie_irq_sense (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // card side
    input wire logic [rie_pkg::IRQ_NUM-1:0] irq_pin,
    // control
    input wire logic [rie_pkg::IRQ_NUM-1:0] irq_mask,
    input wire logic [rie_pkg::IRQ_NUM-1:0] pend_clear,
    // status and requests
    output logic [rie_pkg::IRQ_NUM-1:0] irq_pend,
    output logic [rie_pkg::IRQ_NUM-1:0] irq_req
);
    import rie_pkg::*;

    logic [IRQ_NUM-1:0] pin_prev_reg;
    logic [IRQ_NUM-1:0] pend_reg;
    logic [IRQ_NUM-1:0] req_reg;

    // ************************************
    // per-line sense
    // ************************************
    genvar k;
    generate
        for (k = 0; k < IRQ_NUM; k++) begin : g_line
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_prev_reg[k] <= 1'b0;
                    pend_reg[k] <= 1'b0;
                end else begin
                    pin_prev_reg[k] <= irq_pin[k];
                    if (k == EDGE_IRQ) begin
                        // a new edge beats a clear in the same cycle
                        if (irq_pin[k] && !pin_prev_reg[k]) begin
                            pend_reg[k] <= 1'b1;
                        end else if (pend_clear[k]) begin
                            pend_reg[k] <= 1'b0;
                        end
                    end else begin
                        pend_reg[k] <= irq_pin[k];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= '0;
        end else begin
            req_reg <= pend_reg & ~irq_mask;
        end
    end

    assign irq_pend = pend_reg;
    assign irq_req = req_reg;

    // ************************************
    // checks
    // ************************************
    a_edge_sets_pend: assert property (@(posedge pclk) disable iff (!presetn)
        irq_pin[EDGE_IRQ] && !pin_prev_reg[EDGE_IRQ] |=> irq_pend[EDGE_IRQ])
        else $error("rising edge on line one did not set its pending bit");
    a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_mask == $past(irq_mask)) |-> ((irq_req & $past(irq_mask)) == '0))
        else $error("masked interrupt line reached the processor");

endmodule : rie_irq_sense

// file: src/rie_pkg.sv
// constants and types shared by the reduced isa expansion port
package rie_pkg;

    // ************************************
    // processor addresses
    // ************************************
    localparam logic [31:0] ADDR_SEL_ADDR = 32'h1100_0780;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h1100_0784;
    localparam logic [31:0] IRQ_PEND_ADDR = 32'h1100_0788;
    localparam logic [31:0] PORT_STAT_ADDR = 32'h1100_078C;
    localparam logic [31:0] MEM_WIN_BASE = 32'h1B80_0000;
    localparam logic [31:0] IO_WIN_BASE = 32'h1BC0_0000;
    localparam int WIN_LSB = 22;

    // ************************************
    // field layout and reset values
    // ************************************
    localparam int BANK_W = 2;
    localparam int MEM_BANK_LSB = 0;
    localparam int IO_BANK_LSB = 4;
    localparam int SEL_W = 8;
    localparam logic [7:0] ADDR_SEL_RESET = 8'h00;
    localparam int IRQ_NUM = 4;
    localparam int EDGE_IRQ = 0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'hE;
    localparam int DMA_NUM = 2;
    localparam int STAT_WIDE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_DREQ_LSB = 2;

    // ************************************
    // card bus shape and timing
    // ************************************
    localparam int ISA_ADDR_W = 22;
    localparam int ISA_DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int WAIT_CNT_W = 2;
    localparam logic [1:0] WAIT_CYCLES = 2'h2;
    localparam logic [3:0] CMD_IDLE = 4'hF;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DONE} rie_state_t;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_ADDR, SEL_MASK, SEL_PEND, SEL_STAT, SEL_MEM, SEL_IO
    } rie_sel_t;

endpackage : rie_pkg

// file: src/rie_port.sv
// reduced isa expansion port: apb bridge to a two-wait card bus
// ************************************
// Functional notes
// - memory cycles drive upper card address from select register bits 1:0
// - i/o cycles are memory mapped; upper address from select bits 5:4
// - every card cycle carries two wait cycles
// - eight-bit cycles use the same two-wait timing, and chan_ready low stretches them like wide ones
// - four interrupt request inputs, lines one to four
// - no low-megabyte memory strobes are generated here
// - two dma request inputs and two acknowledge outputs, active low
// - external buffer gate (active low) and direction outputs
// - eight-bit targets exchange data on the low lane only
// - no internal pull-up; undriven wide-select reads high, narrow
// - address lines stay latched for the whole cycle; no latch strobe
// - interrupt line one is sensed on its rising edge
// - interrupt lines two to four are masked after reset
// - no channel-check input exists
// - no bus clock output; everything is timed by pclk
// - memory window 1B800000h..1BBFFFFFh, i/o window the 4 MB above
// - upper-address select register sits at 11000780h
// ************************************
`timescale 1ns/1ps
module rie_port (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // card address and data
    output logic [rie_pkg::BANK_W-1:0] card_upper_addr,
    output logic [rie_pkg::ISA_ADDR_W-1:0] isa_addr,
    input wire logic [rie_pkg::ISA_DATA_W-1:0] isa_data_in,
    output logic [rie_pkg::ISA_DATA_W-1:0] isa_data_out,
    output logic [1:0] isa_data_oe,
    // card strobes and responses
    output logic mem_read_n,
    output logic mem_write_n,
    output logic io_read_n,
    output logic io_write_n,
    input wire logic mem_wide_sel_n,
    input wire logic io_wide_sel_n,
    input wire logic chan_ready,
    // external data buffer
    output logic ext_buffer_gate_n,
    output logic ext_buffer_rd,
    // interrupts
    input wire logic [rie_pkg::IRQ_NUM-1:0] irq_pin,
    output logic [rie_pkg::IRQ_NUM-1:0] irq_req,
    // dma
    input wire logic [rie_pkg::DMA_NUM-1:0] dma_request_n,
    output logic [rie_pkg::DMA_NUM-1:0] dma_acknowledge_n,
    output logic [rie_pkg::DMA_NUM-1:0] cpu_dma_req,
    input wire logic [rie_pkg::DMA_NUM-1:0] cpu_dma_ack
);
    import rie_pkg::*;

    // all checks run on pclk and sleep while reset is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ************************************
    // decode
    // ************************************
    function automatic rie_sel_t decode(input logic [31:0] a);
        rie_sel_t s;
        s = SEL_NONE;
        if (a[31:WIN_LSB] == MEM_WIN_BASE[31:WIN_LSB]) s = SEL_MEM;
        else if (a[31:WIN_LSB] == IO_WIN_BASE[31:WIN_LSB]) s = SEL_IO;
        else if (a == ADDR_SEL_ADDR) s = SEL_ADDR;
        else if (a == IRQ_MASK_ADDR) s = SEL_MASK;
        else if (a == IRQ_PEND_ADDR) s = SEL_PEND;
        else if (a == PORT_STAT_ADDR) s = SEL_STAT;
        return s;
    endfunction : decode

    // one-hot low strobe: bit0 mem rd, bit1 mem wr, bit2 io rd, bit3 io wr
    function automatic logic [3:0] strobe_code(input logic io, input logic wr);
        logic [3:0] c;
        c = CMD_IDLE;
        c[{io, wr}] = 1'b0;
        return c;
    endfunction : strobe_code

    rie_sel_t sel;
    rie_state_t state_reg;
    logic acc;
    logic isa_hit;
    logic reg_wr;
    logic io_reg;
    logic wr_reg;
    logic wide_reg;
    logic [WAIT_CNT_W-1:0] wait_cnt_reg;
    logic [3:0] cmd_n_reg;
    logic [SEL_W-1:0] addr_sel_reg;
    logic [IRQ_NUM-1:0] irq_mask_reg;
    logic [IRQ_NUM-1:0] irq_pend;
    logic [IRQ_NUM-1:0] pend_clear;
    logic [31:0] prdata_reg;
    logic [DMA_NUM-1:0] dreq_reg;
    logic [DMA_NUM-1:0] dack_n_reg;

    assign sel = decode(paddr);
    assign acc = psel && penable;
    assign isa_hit = (sel == SEL_MEM) || (sel == SEL_IO);
    // card cycles hold the apb access phase until the card cycle is over
    assign pready = acc && (!isa_hit || (state_reg == ST_DONE));
    assign pslverr = acc && (sel == SEL_NONE);
    assign reg_wr = acc && pwrite && !isa_hit;

    // ************************************
    // registers
    // ************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_sel_reg <= ADDR_SEL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (reg_wr) begin
            if (sel == SEL_ADDR) addr_sel_reg <= pwdata[SEL_W-1:0];
            if (sel == SEL_MASK) irq_mask_reg <= pwdata[IRQ_NUM-1:0];
        end
    end

    assign pend_clear = (reg_wr && sel == SEL_PEND) ? pwdata[IRQ_NUM-1:0] : '0;

    // register reads load in the setup phase so data is ready with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel && !penable) begin
            case (sel)
                SEL_ADDR: prdata_reg <= {24'h0, addr_sel_reg};
                SEL_MASK: prdata_reg <= {28'h0, irq_mask_reg};
                SEL_PEND: prdata_reg <= {28'h0, irq_pend};
                SEL_STAT: prdata_reg <= {28'h0, dreq_reg, (state_reg != ST_IDLE), wide_reg};
                default: prdata_reg <= '0;
            endcase
        end else if (state_reg == ST_CMD && wait_cnt_reg == WAIT_CYCLES && chan_ready) begin
            if (wide_reg) prdata_reg <= {16'h0, isa_data_in};
            else prdata_reg <= {24'h0, isa_data_in[LANE_W-1:0]};
        end
    end
    assign prdata = prdata_reg;

    // ************************************
    // card cycle sequencer
    // ************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            io_reg <= 1'b0;
            wr_reg <= 1'b0;
            wide_reg <= 1'b0;
            wait_cnt_reg <= '0;
            cmd_n_reg <= CMD_IDLE;
            card_upper_addr <= '0;
            isa_addr <= '0;
            isa_data_out <= '0;
            isa_data_oe <= '0;
            ext_buffer_gate_n <= 1'b1;
            ext_buffer_rd <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (acc && isa_hit) begin
                        // address is latched once and held: no latch strobe
                        io_reg <= (sel == SEL_IO);
                        wr_reg <= pwrite;
                        isa_addr <= paddr[ISA_ADDR_W-1:0];
                        if (sel == SEL_IO) begin
                            card_upper_addr <= addr_sel_reg[IO_BANK_LSB +: BANK_W];
                        end else begin
                            card_upper_addr <= addr_sel_reg[MEM_BANK_LSB +: BANK_W];
                        end
                        isa_data_out <= pwdata[ISA_DATA_W-1:0];
                        isa_data_oe <= {1'b0, pwrite};
                        ext_buffer_gate_n <= 1'b0;
                        ext_buffer_rd <= !pwrite;
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // pins idle high without a driver, so high means narrow
                    wide_reg <= io_reg ? !io_wide_sel_n : !mem_wide_sel_n;
                    isa_data_oe[1] <= wr_reg && (io_reg ? !io_wide_sel_n : !mem_wide_sel_n);
                    cmd_n_reg <= strobe_code(io_reg, wr_reg);
                    wait_cnt_reg <= '0;
                    state_reg <= ST_CMD;
                end
                ST_CMD: begin
                    // the wait count is the same for both widths
                    if (wait_cnt_reg != WAIT_CYCLES) begin
                        wait_cnt_reg <= wait_cnt_reg + 1'b1;
                    end else if (chan_ready) begin
                        cmd_n_reg <= CMD_IDLE;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // buffer stays open one cycle after the strobe for data hold
                    ext_buffer_gate_n <= 1'b1;
                    isa_data_oe <= '0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // every card strobe comes from a pclk flop; no separate bus clock exists
    assign mem_read_n = cmd_n_reg[0];
    assign mem_write_n = cmd_n_reg[1];
    assign io_read_n = cmd_n_reg[2];
    assign io_write_n = cmd_n_reg[3];

    // ************************************
    // interrupts and dma
    // ************************************
    // only the four request lines feed interrupts; no channel-check input
    rie_irq_sense u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .irq_pin(irq_pin),
        .irq_mask(irq_mask_reg),
        .pend_clear(pend_clear),
        .irq_pend(irq_pend),
        .irq_req(irq_req)
    );

    // the processor dma engine moves memory to memory; the pins just relay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dreq_reg <= '0;
            dack_n_reg <= '1;
        end else begin
            dreq_reg <= ~dma_request_n;
            dack_n_reg <= ~cpu_dma_ack;
        end
    end
    assign cpu_dma_req = dreq_reg;
    assign dma_acknowledge_n = dack_n_reg;

    // ************************************
    // checks
    // ************************************
    a_mem_bank_src: assert property (
        state_reg == ST_ADDR && !io_reg |->
        card_upper_addr == addr_sel_reg[MEM_BANK_LSB +: BANK_W])
        else $error("memory cycle upper address differs from select bits");
    a_io_bank_src: assert property (
        state_reg == ST_ADDR && io_reg |->
        card_upper_addr == addr_sel_reg[IO_BANK_LSB +: BANK_W])
        else $error("i/o cycle upper address differs from select bits");
    a_strobe_min_len: assert property (
        $fell(&cmd_n_reg) |-> !(&cmd_n_reg) [*3])
        else $error("card strobe shorter than two wait cycles");
    a_narrow_no_stretch: assert property (
        $fell(&cmd_n_reg) && !wide_reg ##2 chan_ready |=> &cmd_n_reg)
        else $error("narrow cycle ran past the two-wait timing");
    a_ready_holds: assert property (
        state_reg == ST_CMD && wait_cnt_reg == WAIT_CYCLES && !chan_ready |=>
        state_reg == ST_CMD && !(&cmd_n_reg))
        else $error("cycle ended while the target held ready low");
    a_narrow_lane: assert property (
        state_reg == ST_DONE && !wide_reg |-> !isa_data_oe[1] && prdata_reg[31:LANE_W] == '0)
        else $error("narrow cycle used the upper data lane");
    a_wide_sample: assert property (
        state_reg == ST_ADDR |=>
        wide_reg == (io_reg ? !$past(io_wide_sel_n) : !$past(mem_wide_sel_n)))
        else $error("lane width does not follow the sampled wide-select");
    a_addr_held: assert property (
        state_reg != ST_IDLE && $past(state_reg) != ST_IDLE |->
        $stable(isa_addr) && $stable(card_upper_addr))
        else $error("card address changed inside a cycle");
    a_buffer_ctrl: assert property (
        !(&cmd_n_reg) |-> !ext_buffer_gate_n && ext_buffer_rd == !wr_reg)
        else $error("buffer gate or direction wrong during a strobe");
    a_unmapped_err: assert property (
        acc && sel == SEL_NONE |-> pready && pslverr)
        else $error("unmapped access not answered with an error");

endmodule : rie_port
